// ==== verilog/drive_pkg.sv ====
// constants and types shared by the stepper drive configuration logic
//
// Contract
// - switch8 on: resolution 200*2^n, n=0 software
// - switch8 off: index picks 1000..25000 table
// - switches 1-3 select current, 0 is software
// - reduce to 60% after 0.4 s idle
// - switch four on enables standstill reduction
// - two switch-four changes in 1 s start selftest
// - fault lights alarm, frees shaft, holds until reset
package drive_pkg;

   // clock rate and documented times
   localparam int unsigned CLK_HZ = 25000000;
   localparam int unsigned STANDSTILL_MS = 400;
   localparam int unsigned SELFTEST_WINDOW_MS = 1000;
   localparam int unsigned STANDSTILL_CYCLES = CLK_HZ / 1000 * STANDSTILL_MS;
   localparam int unsigned SELFTEST_CYCLES =
      CLK_HZ / 1000 * SELFTEST_WINDOW_MS;
   localparam int unsigned CNT_W = 25;

   // resolution tables, steps per revolution
   localparam logic [15:0] RES_BASE = 16'h00c8;
   localparam logic [15:0] RES_TABLE_B [8] = '{16'h03e8, 16'h07d0,
      16'h0fa0, 16'h1388, 16'h1f40, 16'h2710, 16'h4e20, 16'h61a8};

   // current table in tenths of an ampere, code 0 unused
   localparam logic [7:0] CUR_TABLE [8] = '{8'h00, 8'h20, 8'h28,
      8'h31, 8'h39, 8'h40, 8'h49, 8'h53};
   localparam logic [7:0] CUR_MIN = 8'h05;
   localparam logic [7:0] CUR_MAX = 8'h53;
   localparam logic [15:0] REDUCE_PCT = 16'h003c;
   localparam logic [15:0] PCT_FULL = 16'h0064;

   // register byte offsets
   localparam logic [7:0] OFS_CTRL = 8'h00;
   localparam logic [7:0] OFS_STATUS = 8'h04;
   localparam logic [7:0] OFS_RES = 8'h08;
   localparam logic [7:0] OFS_CUR = 8'h0c;
   localparam logic [7:0] OFS_POS = 8'h10;
   localparam logic [7:0] OFS_INT_STAT = 8'h14;
   localparam logic [7:0] OFS_INT_CLR = 8'h18;
   localparam logic [7:0] OFS_INT_EN = 8'h1c;

   // field positions and reset values
   localparam int unsigned CTRL_CUR_LSB = 16;
   localparam logic [15:0] SW_RES_RST = 16'h0190;
   localparam logic [7:0] SW_CUR_RST = 8'h20;
   localparam int unsigned INT_SELFTEST = 0;
   localparam int unsigned INT_FAULT = 1;
   localparam int unsigned INT_REDUCE = 2;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   // synchronised pin bundle, sw[0] is switch one, high means on
   typedef struct packed {
      logic fault;
      logic enable;
      logic dir;
      logic step;
      logic [7:0] sw;
   } pins_t;

   // whole state of the drive configuration block
   typedef struct packed {
      logic awready;
      logic wready;
      logic aw_got;
      logic w_got;
      logic [7:0] awaddr;
      logic [31:0] wdata;
      logic [3:0] wstrb;
      logic bvalid;
      logic [1:0] bresp;
      logic arready;
      logic rvalid;
      logic [31:0] rdata;
      logic [1:0] rresp;
      logic step_prev;
      logic sw4_prev;
      logic [CNT_W-1:0] idle_cnt;
      logic [CNT_W-1:0] win_cnt;
      logic win_run;
      logic reduced;
      logic selftest;
      logic fault;
      logic drive_off;
      logic alarm;
      logic [31:0] position;
      logic [15:0] steps;
      logic [7:0] cur_sel;
      logic [7:0] cur_out;
      logic [15:0] sw_res;
      logic [7:0] sw_cur;
      logic [2:0] int_stat;
      logic [2:0] int_en;
      logic irq;
   } state_t;

endpackage

// ==== verilog/sync2.sv ====
// two flip-flop synchroniser for a bundle of pin levels
`timescale 1ns/1ps
module sync2 #(
   parameter int WIDTH = 1
) (
   input wire logic aclk, // system clock
   input wire logic aresetn, // synchronous reset, active low
   input wire logic [WIDTH-1:0] d, // asynchronous pin levels
   output logic [WIDTH-1:0] q // levels safe to use on aclk
);
   logic [WIDTH-1:0] meta_q; // first stage, read by q only

   // two stages; nothing but the second stage looks at the first
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         meta_q <= '0;
         q <= '0;
      end else begin
         meta_q <= d;
         q <= meta_q;
      end
   end
endmodule

// ==== verilog/stepper_drive_switch_config.sv ====
// switch decode, standstill reduction, selftest trigger and fault logic
`timescale 1ns/1ps
module stepper_drive_switch_config
   import drive_pkg::*;
#(
   parameter int unsigned IDLE_CYCLES = STANDSTILL_CYCLES,
   parameter int unsigned WINDOW_CYCLES = SELFTEST_CYCLES
) (
   input wire logic aclk, // system clock, 25 MHz
   input wire logic aresetn, // synchronous reset, active low
   input wire logic step_pulse_in, // step command, rising edge steps
   input wire logic direction_in, // high counts up
   input wire logic drive_enable_in, // high enables the drive
   input wire logic fault_in, // power stage fault level, high
   input wire logic current_select_bit0, // switch one
   input wire logic current_select_bit1, // switch two
   input wire logic current_select_bit2, // switch three
   input wire logic standstill_and_selftest_switch, // switch four
   input wire logic microstep_select_bit0, // switch five
   input wire logic microstep_select_bit1, // switch six
   input wire logic microstep_select_bit2, // switch seven
   input wire logic microstep_table_select, // switch eight
   input wire logic [7:0] s_axi_awaddr, // write address
   input wire logic s_axi_awvalid, // write address valid
   output logic s_axi_awready, // write address ready
   input wire logic [31:0] s_axi_wdata, // write data
   input wire logic [3:0] s_axi_wstrb, // write byte strobes
   input wire logic s_axi_wvalid, // write data valid
   output logic s_axi_wready, // write data ready
   output logic [1:0] s_axi_bresp, // write response
   output logic s_axi_bvalid, // write response valid
   input wire logic s_axi_bready, // write response ready
   input wire logic [7:0] s_axi_araddr, // read address
   input wire logic s_axi_arvalid, // read address valid
   output logic s_axi_arready, // read address ready
   output logic [31:0] s_axi_rdata, // read data
   output logic [1:0] s_axi_rresp, // read response
   output logic s_axi_rvalid, // read data valid
   input wire logic s_axi_rready, // read data ready
   output logic irq, // level, enabled status bit set
   output logic alarm_led, // lit while in fault
   output logic drive_off, // high frees the motor shaft
   output logic [15:0] steps_per_rev, // active microstep resolution
   output logic [7:0] motor_current, // current command, 0.1 A units
   output logic current_reduced, // standstill reduction active
   output logic selftest_start, // one-cycle selftest request
   output logic [31:0] position // commanded position in microsteps
);

   pins_t pin_s; // synchronised pins
   state_t st_q; // registered state
   state_t st_d; // next state
   logic step_rise; // step pulse edge
   logic [2:0] res_idx; // resolution index from switches
   logic [2:0] cur_code; // current code from switches
   logic sw4; // switch four level
   logic aw_now; // write address present this cycle
   logic w_now; // write data present this cycle

   // every pin is a foreign level, so all pass two flops first
   sync2 #(
      .WIDTH($bits(pins_t))
   ) u_sync (
      .aclk(aclk),
      .aresetn(aresetn),
      .d({fault_in, drive_enable_in, direction_in, step_pulse_in,
         microstep_table_select, microstep_select_bit2,
         microstep_select_bit1, microstep_select_bit0,
         standstill_and_selftest_switch, current_select_bit2,
         current_select_bit1, current_select_bit0}),
      .q(pin_s)
   );

   // merge a written word into a register under byte strobes
   function automatic logic [31:0] merge(input logic [31:0] old,
      input logic [31:0] val, input logic [3:0] strb);
      logic [31:0] r;
      r = old;
      for (int i = 0; i < 4; i++) begin
         if (strb[i]) begin
            r[i*8 +: 8] = val[i*8 +: 8];
         end
      end
      return r;
   endfunction

   // sixty percent of a current value
   function automatic logic [7:0] reduce(input logic [7:0] c);
      logic [15:0] p;
      p = ({8'h00, c} * REDUCE_PCT) / PCT_FULL;
      return p[7:0];
   endfunction

   // decoded switch fields; an off switch adds to the index
   assign step_rise = pin_s.step & ~st_q.step_prev;
   assign res_idx = ~pin_s.sw[6:4];
   assign cur_code = pin_s.sw[2:0];
   assign sw4 = pin_s.sw[3];
   assign aw_now = st_q.aw_got | (s_axi_awvalid & st_q.awready);
   assign w_now = st_q.w_got | (s_axi_wvalid & st_q.wready);

   // next-state logic for the whole block
   always_comb begin
      logic [31:0] ctrl_word;
      logic [7:0] sw_cur_w;
      logic [2:0] ev;
      logic [2:0] clr;
      ctrl_word = {8'h00, st_q.sw_cur, st_q.sw_res};
      sw_cur_w = 8'h00;
      ev = 3'h0;
      clr = 3'h0;
      st_d = st_q;
      st_d.selftest = 1'b0;
      st_d.step_prev = pin_s.step;
      st_d.sw4_prev = sw4;

      // resolution decode, table chosen by switch eight
      if (pin_s.sw[7]) begin
         if (res_idx == 3'h0) begin
            st_d.steps = st_q.sw_res;
         end else begin
            st_d.steps = RES_BASE << res_idx;
         end
      end else begin
         st_d.steps = RES_TABLE_B[res_idx];
      end

      // operating current decode
      if (cur_code == 3'h0) begin
         st_d.cur_sel = st_q.sw_cur;
      end else begin
         st_d.cur_sel = CUR_TABLE[cur_code];
      end

      // standstill timer; a step or switch four off restores current
      if (step_rise || !sw4) begin
         st_d.idle_cnt = '0;
         st_d.reduced = 1'b0;
      end else if (!st_q.reduced) begin
         if (st_q.idle_cnt >= CNT_W'(IDLE_CYCLES - 1)) begin
            st_d.reduced = 1'b1;
            ev[INT_REDUCE] = 1'b1;
         end else begin
            st_d.idle_cnt = st_q.idle_cnt + 1'b1;
         end
      end

      // current command, scaled while reduced, zero in fault
      if (st_q.fault) begin
         st_d.cur_out = 8'h00;
      end else if (st_q.reduced) begin
         st_d.cur_out = reduce(st_q.cur_sel);
      end else begin
         st_d.cur_out = st_q.cur_sel;
      end

      // double toggle detector on switch four
      if (st_q.win_run) begin
         if (st_q.win_cnt >= CNT_W'(WINDOW_CYCLES - 1)) begin
            st_d.win_run = 1'b0; // window closed, toggle forgotten
         end else begin
            st_d.win_cnt = st_q.win_cnt + 1'b1;
         end
      end
      if (sw4 != st_q.sw4_prev) begin
         if (st_q.win_run) begin
            st_d.win_run = 1'b0;
            st_d.selftest = 1'b1;
            ev[INT_SELFTEST] = 1'b1;
         end else begin
            st_d.win_run = 1'b1;
            st_d.win_cnt = '0;
         end
      end

      // fault is sticky until reset, the only way out
      if (pin_s.fault && !st_q.fault) begin
         st_d.fault = 1'b1;
         ev[INT_FAULT] = 1'b1;
      end
      st_d.alarm = st_d.fault;
      st_d.drive_off = st_d.fault | ~pin_s.enable;

      // position follows steps while enabled and healthy
      if (step_rise && pin_s.enable && !st_q.fault) begin
         if (pin_s.dir) begin
            st_d.position = st_q.position + 32'h1;
         end else begin
            st_d.position = st_q.position - 32'h1;
         end
      end

      // write channel: address and data taken in either order
      if (s_axi_awvalid && st_q.awready) begin
         st_d.aw_got = 1'b1;
         st_d.awaddr = s_axi_awaddr;
      end
      if (s_axi_wvalid && st_q.wready) begin
         st_d.w_got = 1'b1;
         st_d.wdata = s_axi_wdata;
         st_d.wstrb = s_axi_wstrb;
      end
      if (st_q.bvalid && s_axi_bready) begin
         st_d.bvalid = 1'b0;
      end
      if (aw_now && w_now && !st_q.bvalid) begin
         st_d.aw_got = 1'b0;
         st_d.w_got = 1'b0;
         st_d.bvalid = 1'b1;
         st_d.bresp = RESP_OKAY;
         case (st_d.awaddr)
            OFS_CTRL: begin
               ctrl_word = merge(ctrl_word, st_d.wdata, st_d.wstrb);
               st_d.sw_res = ctrl_word[15:0];
               sw_cur_w = ctrl_word[CTRL_CUR_LSB +: 8];
               // clamp software current into the legal span
               if (sw_cur_w < CUR_MIN) begin
                  st_d.sw_cur = CUR_MIN;
               end else if (sw_cur_w > CUR_MAX) begin
                  st_d.sw_cur = CUR_MAX;
               end else begin
                  st_d.sw_cur = sw_cur_w;
               end
            end
            OFS_INT_CLR: begin
               if (st_d.wstrb[0]) begin
                  clr = st_d.wdata[2:0];
               end
            end
            OFS_INT_EN: begin
               if (st_d.wstrb[0]) begin
                  st_d.int_en = st_d.wdata[2:0];
               end
            end
            OFS_STATUS, OFS_RES, OFS_CUR, OFS_POS, OFS_INT_STAT: begin
               st_d.bresp = RESP_OKAY; // read-only, write ignored
            end
            default: begin
               st_d.bresp = RESP_SLVERR; // unmapped
            end
         endcase
      end
      st_d.awready = ~st_d.aw_got & ~st_d.bvalid;
      st_d.wready = ~st_d.w_got & ~st_d.bvalid;

      // read channel: one-cycle answer from the current state
      if (st_q.rvalid && s_axi_rready) begin
         st_d.rvalid = 1'b0;
      end
      if (s_axi_arvalid && st_q.arready) begin
         st_d.rvalid = 1'b1;
         st_d.rresp = RESP_OKAY;
         case (s_axi_araddr)
            OFS_CTRL: st_d.rdata = ctrl_word;
            OFS_STATUS: begin
               st_d.rdata = {27'h0, st_q.win_run, sw4, pin_s.enable,
                  st_q.reduced, st_q.fault};
            end
            OFS_RES: st_d.rdata = {16'h0, st_q.steps};
            OFS_CUR: st_d.rdata = {16'h0, st_q.cur_sel, st_q.cur_out};
            OFS_POS: st_d.rdata = st_q.position;
            OFS_INT_STAT: st_d.rdata = {29'h0, st_q.int_stat};
            OFS_INT_EN: st_d.rdata = {29'h0, st_q.int_en};
            OFS_INT_CLR: st_d.rdata = 32'h0; // write-only
            default: begin
               st_d.rdata = 32'h0;
               st_d.rresp = RESP_SLVERR;
            end
         endcase
      end
      st_d.arready = ~st_d.rvalid;

      // sticky events; a set in the clearing cycle wins
      st_d.int_stat = (st_q.int_stat & ~clr) | ev;
      st_d.irq = |(st_d.int_stat & st_d.int_en);
   end

   // single state register
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         st_q <= '0;
         st_q.awready <= 1'b1;
         st_q.wready <= 1'b1;
         st_q.arready <= 1'b1;
         st_q.drive_off <= 1'b1; // shaft free until enable is seen
         st_q.steps <= SW_RES_RST;
         st_q.sw_res <= SW_RES_RST;
         st_q.sw_cur <= SW_CUR_RST;
         st_q.cur_sel <= SW_CUR_RST;
      end else begin
         st_q <= st_d;
      end
   end

   // outputs straight from the state register
   assign s_axi_awready = st_q.awready;
   assign s_axi_wready = st_q.wready;
   assign s_axi_bvalid = st_q.bvalid;
   assign s_axi_bresp = st_q.bresp;
   assign s_axi_arready = st_q.arready;
   assign s_axi_rvalid = st_q.rvalid;
   assign s_axi_rdata = st_q.rdata;
   assign s_axi_rresp = st_q.rresp;
   assign irq = st_q.irq;
   assign alarm_led = st_q.alarm;
   assign drive_off = st_q.drive_off;
   assign steps_per_rev = st_q.steps;
   assign motor_current = st_q.cur_out;
   assign current_reduced = st_q.reduced;
   assign selftest_start = st_q.selftest;
   assign position = st_q.position;

   // checks on the decode and supervision behaviour
   property p_res_power;
      @(posedge aclk) disable iff (!aresetn)
      (pin_s.sw[7] && res_idx != 3'h0) |=>
         steps_per_rev == (RES_BASE << $past(res_idx));
   endproperty
   a_res_power: assert property (p_res_power)
      else $error("power-of-two resolution wrong");

   property p_res_table;
      @(posedge aclk) disable iff (!aresetn)
      !pin_s.sw[7] |=> steps_per_rev == RES_TABLE_B[$past(res_idx)];
   endproperty
   a_res_table: assert property (p_res_table)
      else $error("decimal resolution wrong");

   property p_cur_table;
      @(posedge aclk) disable iff (!aresetn)
      cur_code != 3'h0 |=> st_q.cur_sel == CUR_TABLE[$past(cur_code)];
   endproperty
   a_cur_table: assert property (p_cur_table)
      else $error("current code decode wrong");

   property p_reduce_level;
      @(posedge aclk) disable iff (!aresetn)
      (current_reduced && !st_q.fault) |=>
         motor_current == reduce($past(st_q.cur_sel));
   endproperty
   a_reduce_level: assert property (p_reduce_level)
      else $error("reduced current not sixty percent");

   property p_step_restores;
      @(posedge aclk) disable iff (!aresetn)
      step_rise |=> !current_reduced ##1 !current_reduced;
   endproperty
   a_step_restores: assert property (p_step_restores)
      else $error("step did not restore full current");

   property p_sw4_off_full;
      @(posedge aclk) disable iff (!aresetn)
      !sw4 |=> !current_reduced;
   endproperty
   a_sw4_off_full: assert property (p_sw4_off_full)
      else $error("reduction active with switch four off");

   property p_selftest_cause;
      @(posedge aclk) disable iff (!aresetn)
      selftest_start |-> $past(st_q.win_run) && $past(sw4 != st_q.sw4_prev);
   endproperty
   a_selftest_cause: assert property (p_selftest_cause)
      else $error("selftest without double toggle");

   property p_fault_holds;
      @(posedge aclk) disable iff (!aresetn)
      st_q.fault |=> (alarm_led && drive_off && st_q.fault)[*3];
   endproperty
   a_fault_holds: assert property (p_fault_holds)
      else $error("fault released or shaft driven");

   property p_position_step;
      @(posedge aclk) disable iff (!aresetn)
      (step_rise && pin_s.enable && !st_q.fault) |=>
         position == $past(position) + ($past(pin_s.dir) ? 32'h1 : -32'h1);
   endproperty
   a_position_step: assert property (p_position_step)
      else $error("position did not follow step");

   c_selftest: cover property (@(posedge aclk) disable iff (!aresetn)
      selftest_start);
   c_reduced: cover property (@(posedge aclk) disable iff (!aresetn)
      $rose(current_reduced));
   c_fault_irq: cover property (@(posedge aclk) disable iff (!aresetn)
      st_q.fault ##1 irq);
   c_write: cover property (@(posedge aclk) disable iff (!aresetn)
      s_axi_bvalid && s_axi_bready);
endmodule

// ==== dv/motion_ctrl_model.sv ====
// motion controller model driving step, direction and enable levels
`timescale 1ns/1ps
module motion_ctrl_model (
   input wire logic aclk, // system clock
   output logic step_o, // step pulse level
   output logic dir_o, // direction level
   output logic ena_o // enable level
);
   // idle low and disabled until the bench asks otherwise
   initial begin
      step_o = 1'b0;
      dir_o = 1'b0;
      ena_o = 1'b0;
   end
   // n pulses, each level held hold cycles; below 2 the synchroniser
   // could miss an edge, so short holds are lifted to 2
   task automatic move(input int n, input logic d, input int hold);
      int i;
      int h;
      h = (hold < 2) ? 2 : hold;
      dir_o <= d;
      repeat (2) @(posedge aclk); // direction settles ahead of the edge
      for (i = 0; i < n; i++) begin
         step_o <= 1'b1;
         repeat (h) @(posedge aclk);
         step_o <= 1'b0;
         repeat (h) @(posedge aclk);
      end
   endtask
   // enable level changes only between moves
   task automatic set_enable(input logic e);
      ena_o <= e;
      @(posedge aclk);
   endtask
endmodule

// ==== dv/tb.sv ====
// self-checking bench for the stepper drive configuration block
`timescale 1ns/1ps
`define CHK(n, g, e) chk(n, 32'(e), 32'(g))
module tb
   import drive_pkg::*;
;
   logic aclk, aresetn, fault_in, stp, dir, ena; // clock, reset, pins
   logic [7:0] sw; // sw[0] is switch one, high is on
   logic [7:0] awaddr, araddr; // bus addresses
   logic [31:0] wdata, rdata, pos; // bus data, position
   logic [3:0] wstrb; // byte strobes
   logic awvalid, awready, wvalid, wready, bvalid, bready;
   logic arvalid, arready, rvalid, rready;
   logic [1:0] bresp, rresp; // bus responses
   logic irq, alarm, doff, red, st; // status outputs
   logic [15:0] spr; // active resolution
   logic [7:0] mcur; // current command
   int miscompares, num_checks, st_cnt; // counters

   // short counts keep the idle and toggle windows quick to reach
   stepper_drive_switch_config #(.IDLE_CYCLES(20), .WINDOW_CYCLES(50))
   dut_u (.aclk(aclk), .aresetn(aresetn), .step_pulse_in(stp),
      .direction_in(dir), .drive_enable_in(ena), .fault_in(fault_in),
      .current_select_bit0(sw[0]), .current_select_bit1(sw[1]),
      .current_select_bit2(sw[2]),
      .standstill_and_selftest_switch(sw[3]),
      .microstep_select_bit0(sw[4]), .microstep_select_bit1(sw[5]),
      .microstep_select_bit2(sw[6]), .microstep_table_select(sw[7]),
      .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
      .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
      .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
      .s_axi_bvalid(bvalid), .s_axi_bready(bready),
      .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
      .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
      .s_axi_rvalid(rvalid), .s_axi_rready(rready), .irq(irq),
      .alarm_led(alarm), .drive_off(doff), .steps_per_rev(spr),
      .motor_current(mcur), .current_reduced(red), .selftest_start(st),
      .position(pos));

   motion_ctrl_model mc_u (.aclk(aclk), .step_o(stp), .dir_o(dir),
      .ena_o(ena));

   // 25 MHz clock
   initial begin
      aclk = 1'b0;
      forever #20 aclk = ~aclk;
   end

   // selftest pulses are one cycle wide, so count them as they pass
   always @(posedge aclk) begin
      if (st === 1'b1) st_cnt++;
   end

   task automatic chk(input string n, input logic [31:0] e,
      input logic [31:0] g);
      num_checks++;
      if (g !== e) begin
         miscompares++;
         $display("[ERR] %s expected %h seen %h", n, e, g);
      end
   endtask

   task automatic cyc(input int n);
      repeat (n) @(posedge aclk);
   endtask

   // reset is held well past the synchroniser depth
   task automatic rst();
      aresetn <= 1'b0;
      cyc(6);
      aresetn <= 1'b1;
      cyc(1);
   endtask

   // address and data offered together, each dropped once taken
   task automatic axw(input logic [7:0] a, input logic [31:0] d,
      output logic [1:0] r);
      logic ga, gw;
      ga = 1'b0;
      gw = 1'b0;
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      while (!(ga && gw)) begin
         @(posedge aclk);
         if (awready && !ga) begin
            ga = 1'b1;
            awvalid <= 1'b0;
         end
         if (wready && !gw) begin
            gw = 1'b1;
            wvalid <= 1'b0;
         end
      end
      bready <= 1'b1;
      // no cycle count assumed; only the watchdog ends a stuck wait
      do begin
         @(posedge aclk);
      end while (bvalid !== 1'b1);
      `CHK("awready while bvalid", awready, 1'b0);
      r = bresp;
      bready <= 1'b0;
   endtask

   task automatic axr(input logic [7:0] a, output logic [31:0] d,
      output logic [1:0] r);
      araddr <= a;
      arvalid <= 1'b1;
      do begin
         @(posedge aclk);
      end while (arready !== 1'b1);
      arvalid <= 1'b0;
      rready <= 1'b1;
      do begin
         @(posedge aclk);
      end while (rvalid !== 1'b1);
      `CHK("arready while rvalid", arready, 1'b0);
      d = rdata;
      r = rresp;
      rready <= 1'b0;
   endtask

   // every resolution code of both tables; motor idle meanwhile
   task automatic t_res();
      logic [15:0] tb8 [8] = '{16'h03e8, 16'h07d0, 16'h0fa0, 16'h1388,
         16'h1f40, 16'h2710, 16'h4e20, 16'h61a8};
      logic [15:0] e;
      int k;
      for (k = 0; k < 16; k++) begin
         sw <= {k[3], ~k[2:0], sw[3:0]};
         cyc(6);
         e = (k[2:0] == 3'h0) ? 16'h0190 : (16'h00c8 << k[2:0]);
         if (!k[3]) e = tb8[k[2:0]];
         `CHK("steps_per_rev", spr, e);
      end
   endtask

   // every current code, code 0 takes the software field
   task automatic t_cur();
      logic [7:0] ct [8] = '{8'h20, 8'h20, 8'h28, 8'h31, 8'h39, 8'h40,
         8'h49, 8'h53};
      int c;
      for (c = 0; c < 8; c++) begin
         sw <= {sw[7:3], c[2:0]};
         cyc(6);
         `CHK("motor_current", mcur, ct[c]);
      end
   endtask

   // software mode via the register bus, plus bus corner cases
   task automatic t_soft();
      logic [31:0] d;
      logic [1:0] r;
      sw <= 8'hf0;
      axw(OFS_CTRL, 32'h006004d2, r);
      `CHK("ctrl bresp", r, RESP_OKAY);
      cyc(6);
      `CHK("soft steps", spr, 16'h04d2);
      `CHK("soft current", mcur, 8'h53);
      axr(OFS_CTRL, d, r);
      `CHK("ctrl read", d, 32'h005304d2);
      axr(8'h40, d, r);
      `CHK("unmapped rresp", r, RESP_SLVERR);
      `CHK("unmapped rdata", d, 32'h0);
      axw(8'h40, 32'h1, r);
      `CHK("unmapped bresp", r, RESP_SLVERR);
      axw(OFS_STATUS, 32'hffffffff, r);
      `CHK("read-only bresp", r, RESP_OKAY);
   endtask

   // standstill reduction: not early, 60 percent, restore, switch off
   task automatic t_idle();
      sw <= 8'h0f;
      cyc(6);
      mc_u.move(1, 1'b1, 2);
      cyc(10);
      `CHK("reduced early", red, 1'b0);
      cyc(25);
      `CHK("reduced", red, 1'b1);
      `CHK("reduced current", mcur, 8'h31);
      mc_u.move(1, 1'b1, 2);
      cyc(3);
      `CHK("restored", red, 1'b0);
      `CHK("restored current", mcur, 8'h53);
      cyc(60);
      sw <= 8'h07;
      cyc(40);
      `CHK("switch off", red, 1'b0);
      `CHK("full current", mcur, 8'h53);
   endtask

   // double toggle inside and outside the window, with the interrupt
   task automatic t_self();
      logic [31:0] d;
      logic [1:0] r;
      int b;
      axw(OFS_INT_EN, 32'h1, r);
      cyc(60);
      b = st_cnt;
      sw <= sw ^ 8'h08;
      cyc(10);
      sw <= sw ^ 8'h08;
      cyc(10);
      `CHK("selftest", st_cnt, b + 1);
      `CHK("irq raised", irq, 1'b1);
      axr(OFS_INT_STAT, d, r);
      `CHK("int_stat", d[0], 1'b1);
      axw(OFS_INT_EN, 32'h0, r);
      cyc(2);
      `CHK("irq masked", irq, 1'b0);
      axw(OFS_INT_EN, 32'h1, r);
      cyc(2);
      `CHK("irq unmasked", irq, 1'b1);
      axw(OFS_INT_CLR, 32'h1, r);
      cyc(2);
      `CHK("irq cleared", irq, 1'b0);
      cyc(60);
      sw <= sw ^ 8'h08;
      cyc(70);
      sw <= sw ^ 8'h08;
      cyc(10);
      `CHK("slow toggles", st_cnt, b + 1);
   endtask

   // position counts both ways and freezes while disabled
   task automatic t_pos();
      logic [31:0] p;
      p = pos;
      mc_u.move(5, 1'b1, 2);
      mc_u.move(3, 1'b0, 3);
      cyc(6);
      `CHK("position", pos, p + 32'h2);
      mc_u.set_enable(1'b0);
      cyc(4);
      `CHK("disabled off", doff, 1'b1);
      mc_u.move(2, 1'b1, 2);
      cyc(6);
      `CHK("disabled pos", pos, p + 32'h2);
      mc_u.set_enable(1'b1);
      cyc(4);
      `CHK("enabled", doff, 1'b0);
   endtask

   // a short fault pulse latches until reset
   task automatic t_fault();
      logic [31:0] p, d;
      logic [1:0] r;
      fault_in <= 1'b1;
      cyc(4);
      fault_in <= 1'b0;
      cyc(6);
      `CHK("alarm", alarm, 1'b1);
      `CHK("shaft free", doff, 1'b1);
      `CHK("fault current", mcur, 8'h00);
      axr(OFS_INT_STAT, d, r);
      `CHK("fault event", d[1], 1'b1);
      `CHK("reduce event", d[2], 1'b1);
      p = pos;
      mc_u.move(2, 1'b1, 2);
      cyc(6);
      `CHK("fault pos", pos, p);
      rst();
      cyc(6);
      `CHK("alarm after reset", alarm, 1'b0);
      `CHK("drive after reset", doff, 1'b0);
   endtask

   task automatic report_and_stop();
      $display("checks %0d miscompares %0d", num_checks, miscompares);
      if (miscompares == 0 && num_checks > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask

   // main sequence
   initial begin
      {aresetn, fault_in, awvalid, wvalid, bready, arvalid, rready} = 0;
      {awaddr, araddr, sw} = 0;
      wdata = 32'h0;
      wstrb = 4'hf;
      rst();
      mc_u.set_enable(1'b1);
      cyc(4);
      t_res();
      t_cur();
      t_soft();
      t_idle();
      t_self();
      t_pos();
      t_fault();
      report_and_stop();
   end

   // watchdog, well beyond the fewer than a thousand cycles the tests need
   initial begin
      cyc(20000);
      miscompares++;
      report_and_stop();
   end
endmodule
